// ---- fbsfc_ctrl.sv ----
// Purpose: primary-side start-up, sync follow and fault sequencer
// Assumes: threshold crossings arrive as asynchronous digital levels
// Notes:   oscillator tick divided from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "fbsfc_params.svh"
module fbsfc_ctrl #(
   parameter logic [9:0]  OSC_DIV     = 10'(`FBSFC_OSC_DIV),
   parameter logic [19:0] RESTART_OSC = 20'(`FBSFC_RESTART_OSC),
   parameter logic [9:0]  SS_STEP     = 10'(`FBSFC_SS_STEP),
   parameter logic [31:0] XCAP_WIN    = 32'(`FBSFC_XCAP_WIN_CYC),
   parameter logic [31:0] STOP_DLY    = 32'(`FBSFC_STOP_DLY_CYC),
   parameter logic [7:0]  PW_MIN      = 8'(`FBSFC_PW_MIN),
   parameter logic [7:0]  PW_MAX      = 8'(`FBSFC_PW_MAX)
) (
   // clock and reset
   input  wire logic CLK_I,
   input  wire logic RST_B_I,
   // comparator levels
   input  wire logic LINE_UV_OK_I,
   input  wire logic LINE_OV_I,
   input  wire logic AUX_OV_I,
   input  wire logic OVERCURRENT_I,
   // sync pulse levels
   input  wire logic SYNC_POS_I,
   input  wire logic SYNC_NEG_I,
   // gate and status
   output var  logic GATE_DRIVE_O,
   output var  logic XCAP_MODE_O,
   output var  logic DISCHARGE_EN_O,
   output var  logic SOFTSTART_O,
   output var  logic CLOSED_LOOP_O,
   output var  logic SHUTDOWN_O
);

   localparam logic [9:0] SS_TON = 10'(`FBSFC_SS_TON_CYC);
   localparam logic [9:0] CL_TON = 10'(`FBSFC_CL_TON_CYC);
   localparam logic [1:0] EDGES  = 2'(`FBSFC_XCAP_EDGES);
   localparam logic [1:0] STOPS  = 2'(`FBSFC_STOP_PULSES);

   fbsfc_pkg::fbsfc_ctl_t r;
   fbsfc_pkg::fbsfc_ctl_t n;

   fbsfc_pulse_if pif ();

   fbsfc_pulse_dec #(
      .PW_MIN (PW_MIN),
      .PW_MAX (PW_MAX)
   ) u_dec (
      .clk_i   (CLK_I),
      .rst_b_i (RST_B_I),
      .pos_i   (SYNC_POS_I),
      .neg_i   (SYNC_NEG_I),
      .pif     (pif)
   );

   always_comb begin
      logic       osc_tick;
      logic       rise;
      logic [1:0] e_nxt;
      logic       line_ok;
      logic       line_ov;
      logic       aux_ov;
      logic       oc;
      logic [9:0] lim;
      osc_tick = 1'b0;
      rise     = 1'b0;
      e_nxt    = 2'h0;
      line_ok  = 1'b0;
      line_ov  = 1'b0;
      aux_ov   = 1'b0;
      oc       = 1'b0;
      lim      = 10'h000;
      n = r;

      // input synchronisers
      n.s1 = {OVERCURRENT_I, AUX_OV_I, LINE_OV_I, LINE_UV_OK_I};
      n.s2 = r.s1;
      line_ok = r.s2[0];
      line_ov = r.s2[1];
      aux_ov  = r.s2[2];
      oc      = r.s2[3];

      // oscillator tick
      osc_tick = (r.osc_cnt == OSC_DIV - 10'h001);
      n.osc_cnt = osc_tick ? 10'h000 : r.osc_cnt + 10'h001;

      // line crossing window
      n.uv_d = line_ok;
      rise = line_ok & ~r.uv_d;
      e_nxt = (rise && r.edges != EDGES) ? r.edges + 2'h1 : r.edges;
      if (!r.win_run) begin
         if (rise) begin
            n.win_run = 1'b1;
            n.win_cnt = 32'h0;
            n.edges   = 2'h1;
         end
      end else if (r.win_cnt == XCAP_WIN - 32'h1) begin
         if (e_nxt == EDGES) begin
            n.xcap = 1'b1;
            n.dis  = 1'b0;
         end else if (r.xcap) begin
            n.dis = 1'b1;
         end
         n.win_run = r.xcap | (e_nxt == EDGES);
         n.win_cnt = 32'h0;
         n.edges   = 2'h0;
      end else begin
         n.win_cnt = r.win_cnt + 32'h1;
         n.edges   = e_nxt;
         if (e_nxt == EDGES) begin
            n.xcap = 1'b1;
            n.dis  = 1'b0;
         end
      end

      // gate on-time counter
      n.on_cnt = r.gate ? r.on_cnt + 10'h001 : 10'h000;

      // sequencer
      case (r.st)
         fbsfc_pkg::ST_OFF: begin
            n.gate = 1'b0;
            if (line_ok && !line_ov) begin
               n.st     = fbsfc_pkg::ST_SOFT;
               n.ss_lim = 10'h000;
            end
         end
         fbsfc_pkg::ST_FAULT: begin
            n.gate = 1'b0;
            if (!line_ov && !aux_ov && !oc) begin
               n.st      = fbsfc_pkg::ST_WAIT;
               n.rst_cnt = 20'h0;
            end
         end
         fbsfc_pkg::ST_WAIT: begin
            n.gate = 1'b0;
            if (osc_tick) begin
               n.rst_cnt = r.rst_cnt + 20'h1;
               if (r.rst_cnt == RESTART_OSC - 20'h1) begin
                  n.st     = fbsfc_pkg::ST_SOFT;
                  n.ss_lim = 10'h000;
               end
            end
         end
         fbsfc_pkg::ST_SOFT: begin
            if (aux_ov || oc) begin
               n.gate = 1'b0;
               n.st   = fbsfc_pkg::ST_FAULT;
            end else if (pif.on_evt) begin
               n.gate    = 1'b1;
               n.st      = fbsfc_pkg::ST_CLOSED;
               n.offs    = 2'h0;
               n.rst_cnt = 20'h0;
            end else if (osc_tick) begin
               lim = (r.ss_lim >= SS_TON - SS_STEP) ? SS_TON : r.ss_lim + SS_STEP;
               n.ss_lim = lim;
               n.gate   = 1'b1;
            end else if (r.gate && (r.on_cnt >= r.ss_lim - 10'h001 || r.on_cnt >= SS_TON - 10'h001)) begin
               n.gate = 1'b0;
            end
         end
         fbsfc_pkg::ST_CLOSED: begin
            if (osc_tick) begin
               n.rst_cnt = r.rst_cnt + 20'h1;
            end
            if (pif.on_evt) begin
               n.gate    = ~oc;
               n.offs    = 2'h0;
               n.rst_cnt = 20'h0;
            end else if (pif.off_evt) begin
               n.gate    = 1'b0;
               n.offs    = r.offs + 2'h1;
               n.rst_cnt = 20'h0;
               if (r.offs == STOPS - 2'h1) begin
                  n.st       = fbsfc_pkg::ST_STOP;
                  n.stop_cnt = 32'h0;
               end
            end else if (oc) begin
               n.gate = 1'b0;
            end else if (r.gate && r.on_cnt == CL_TON - 10'h001) begin
               n.gate    = 1'b0;
               n.st      = fbsfc_pkg::ST_WAIT;
               n.rst_cnt = 20'h0;
            end else if (osc_tick && r.rst_cnt == RESTART_OSC - 20'h1) begin
               n.gate   = 1'b0;
               n.st     = fbsfc_pkg::ST_SOFT;
               n.ss_lim = 10'h000;
            end
         end
         fbsfc_pkg::ST_STOP: begin
            n.gate     = 1'b0;
            n.stop_cnt = r.stop_cnt + 32'h1;
            if (r.stop_cnt == STOP_DLY - 32'h1) begin
               n.st = fbsfc_pkg::ST_LATCH;
            end
         end
         fbsfc_pkg::ST_LATCH: begin
            n.gate = 1'b0;
         end
         default: begin
            n.gate = 1'b0;
            n.st   = fbsfc_pkg::ST_OFF;
         end
      endcase

      // line faults override all but shutdown
      if (r.st != fbsfc_pkg::ST_LATCH) begin
         if (!line_ok) begin
            n.gate = 1'b0;
            n.st   = fbsfc_pkg::ST_OFF;
         end else if (line_ov) begin
            n.gate = 1'b0;
            n.st   = fbsfc_pkg::ST_FAULT;
         end
      end

      // registered status
      n.ss_o = (n.st == fbsfc_pkg::ST_SOFT);
      n.cl_o = (n.st == fbsfc_pkg::ST_CLOSED);
      n.sd_o = (n.st == fbsfc_pkg::ST_LATCH);
   end

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // outputs
   assign GATE_DRIVE_O   = r.gate;
   assign XCAP_MODE_O    = r.xcap;
   assign DISCHARGE_EN_O = r.dis;
   assign SOFTSTART_O    = r.ss_o;
   assign CLOSED_LOOP_O  = r.cl_o;
   assign SHUTDOWN_O     = r.sd_o;

endmodule // fbsfc_ctrl
`default_nettype wire

// ---- fbsfc_params.svh ----
// Purpose: timing counts and limits for the flyback start-up and fault sequencer
// Assumes: 25 MHz system clock, 40 ns period
// Notes:   counts derive from times by integer division (rounds down)
`ifndef FBSFC_PARAMS_SVH
`define FBSFC_PARAMS_SVH

// system clock
`define FBSFC_CLK_HZ       25000000
`define FBSFC_CLK_NS       40

// internal oscillator, nominal rate
`define FBSFC_OSC_HZ       30000
`define FBSFC_OSC_DIV      (`FBSFC_CLK_HZ / `FBSFC_OSC_HZ)

// gate on-time limits
`define FBSFC_SS_TON_NS    19000
`define FBSFC_SS_DUTY_PCT  70
`define FBSFC_CL_TON_NS    25000
`define FBSFC_SS_TON_CYC   (`FBSFC_SS_TON_NS / `FBSFC_CLK_NS)
`define FBSFC_CL_TON_CYC   (`FBSFC_CL_TON_NS / `FBSFC_CLK_NS)

// line crossing window and stop delay
`define FBSFC_XCAP_WIN_MS  64
`define FBSFC_XCAP_EDGES   3
`define FBSFC_XCAP_WIN_CYC (`FBSFC_XCAP_WIN_MS * 1000000 / `FBSFC_CLK_NS)
`define FBSFC_STOP_PULSES  3
`define FBSFC_STOP_DLY_MS  200
`define FBSFC_STOP_DLY_CYC (`FBSFC_STOP_DLY_MS * 1000000 / `FBSFC_CLK_NS)

// restart delay in oscillator cycles, soft-start ramp step
`define FBSFC_RESTART_OSC  1000
`define FBSFC_SS_STEP      1

// sync pulse width window in clock cycles
`define FBSFC_PW_MIN       2
`define FBSFC_PW_MAX       50

`endif

// ---- fbsfc_pkg.sv ----
// Purpose: types for the flyback start-up and fault sequencer
// Assumes: nothing
// Notes:   state structs are registered whole
package fbsfc_pkg;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_FAULT,
      ST_WAIT,
      ST_SOFT,
      ST_CLOSED,
      ST_STOP,
      ST_LATCH
   } fbsfc_state_t;

   typedef struct packed {
      logic [3:0]   s1;
      logic [3:0]   s2;
      logic         uv_d;
      logic [9:0]   osc_cnt;
      logic         win_run;
      logic [31:0]  win_cnt;
      logic [1:0]   edges;
      logic         xcap;
      logic         dis;
      fbsfc_state_t st;
      logic         gate;
      logic [9:0]   on_cnt;
      logic [9:0]   ss_lim;
      logic [1:0]   offs;
      logic [19:0]  rst_cnt;
      logic [31:0]  stop_cnt;
      logic         ss_o;
      logic         cl_o;
      logic         sd_o;
   } fbsfc_ctl_t;

   typedef struct packed {
      logic [1:0]      s1;
      logic [1:0]      s2;
      logic [1:0][7:0] wid;
      logic [1:0]      evt;
   } fbsfc_dec_t;

endpackage

// ---- fbsfc_pulse_if.sv ----
// Purpose: carries decoded sync pulse events
// Assumes: single clock domain
// Notes:   events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface fbsfc_pulse_if;
   logic on_evt;
   logic off_evt;
   modport dec (output on_evt, output off_evt);
   modport ctl (input on_evt, input off_evt);
endinterface
`default_nettype wire

// ---- fbsfc_pulse_dec.sv ----
// Purpose: qualifies positive and negative sync pulses by width
// Assumes: pulse levels arrive asynchronously
// Notes:   event fires on the falling edge of a valid pulse
`timescale 1ns/1ps
`default_nettype none
`include "fbsfc_params.svh"
module fbsfc_pulse_dec #(
   parameter logic [7:0] PW_MIN = 8'(`FBSFC_PW_MIN),
   parameter logic [7:0] PW_MAX = 8'(`FBSFC_PW_MAX)
) (
   // clock and reset
   input  wire logic   clk_i,
   input  wire logic   rst_b_i,
   // pulse levels
   input  wire logic   pos_i,
   input  wire logic   neg_i,
   // events
   fbsfc_pulse_if.dec  pif
);

   fbsfc_pkg::fbsfc_dec_t r;
   fbsfc_pkg::fbsfc_dec_t n;

   function automatic logic in_range(input logic [7:0] w);
      return (w >= PW_MIN) && (w <= PW_MAX);
   endfunction

   always_comb begin
      n = r;
      n.s1 = {neg_i, pos_i};
      n.s2 = r.s1;
      n.evt = 2'h0;
      for (int i = 0; i < 2; i++) begin
         if (r.s2[i]) begin
            if (r.wid[i] != 8'hff) begin
               n.wid[i] = r.wid[i] + 8'h01;
            end
         end else begin
            n.evt[i] = (r.wid[i] != 8'h00) && in_range(r.wid[i]);
            n.wid[i] = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign pif.on_evt  = r.evt[0];
   assign pif.off_evt = r.evt[1];

endmodule // fbsfc_pulse_dec
`default_nettype wire

// ---- fbsfc_monitor.sv ----
// Purpose: port checker for fbsfc_ctrl
// Assumes: one clock, async low reset
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module fbsfc_monitor (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_B_I,
   // levels in
   input wire logic LINE_UV_OK_I,
   input wire logic LINE_OV_I,
   input wire logic AUX_OV_I,
   input wire logic OVERCURRENT_I,
   input wire logic SYNC_POS_I,
   input wire logic SYNC_NEG_I,
   // gate and status
   input wire logic GATE_DRIVE_O,
   input wire logic XCAP_MODE_O,
   input wire logic DISCHARGE_EN_O,
   input wire logic SOFTSTART_O,
   input wire logic CLOSED_LOOP_O,
   input wire logic SHUTDOWN_O
);
   logic [9:0] on_cnt_r;
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         on_cnt_r <= 10'h0;
      end else if (GATE_DRIVE_O) begin
         on_cnt_r <= on_cnt_r + 10'h1;
      end else begin
         on_cnt_r <= 10'h0;
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   sequence uv_low3; !LINE_UV_OK_I [*3]; endsequence
   sequence aux_ss3; (AUX_OV_I && SOFTSTART_O) [*3]; endsequence
   a_ss_on_cap: assert property (SOFTSTART_O |-> on_cnt_r <= 10'h1dc)
      else $error("soft-start on time too long");
   a_cl_on_cap: assert property (on_cnt_r <= 10'h272)
      else $error("gate on time too long");
   a_uv_gate_off: assert property (uv_low3 |=> !GATE_DRIVE_O)
      else $error("gate on under line undervoltage");
   a_ov_gate_off: assert property (LINE_OV_I [*3] |=> !GATE_DRIVE_O)
      else $error("gate on under line overvoltage");
   a_oc_gate_off: assert property (OVERCURRENT_I [*3] |=> !GATE_DRIVE_O)
      else $error("gate on under overcurrent");
   a_aux_gate_off: assert property (aux_ss3 |=> !GATE_DRIVE_O)
      else $error("gate on under aux overvoltage");
   a_stop_latched: assert property (SHUTDOWN_O |=> SHUTDOWN_O && !GATE_DRIVE_O && !SOFTSTART_O)
      else $error("shutdown left");
   a_dis_needs_xcap: assert property (DISCHARGE_EN_O |-> XCAP_MODE_O)
      else $error("discharge without x-cap mode");
   a_xcap_sticky: assert property (XCAP_MODE_O |=> XCAP_MODE_O)
      else $error("x-cap flag dropped");
endmodule // fbsfc_monitor
bind fbsfc_ctrl fbsfc_monitor u_mon (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .LINE_UV_OK_I(LINE_UV_OK_I),
   .LINE_OV_I(LINE_OV_I), .AUX_OV_I(AUX_OV_I), .OVERCURRENT_I(OVERCURRENT_I), .SYNC_POS_I(SYNC_POS_I),
   .SYNC_NEG_I(SYNC_NEG_I), .GATE_DRIVE_O(GATE_DRIVE_O), .XCAP_MODE_O(XCAP_MODE_O),
   .DISCHARGE_EN_O(DISCHARGE_EN_O), .SOFTSTART_O(SOFTSTART_O), .CLOSED_LOOP_O(CLOSED_LOOP_O),
   .SHUTDOWN_O(SHUTDOWN_O));
`default_nettype wire

// ---- fbsfc_sec_model.sv ----
// Purpose: secondary controller sending sync pulses
// Assumes: lines idle low between pulses
// Notes: widths in clock cycles
`timescale 1ns/1ps
`default_nettype none
module fbsfc_sec_model (
   // clock
   input  wire logic clk_i,
   // pulse lines
   output var  logic pos_o,
   output var  logic neg_o
);
   initial begin
      pos_o = 1'h0;
      neg_o = 1'h0;
   end
   // positive turns on, negative turns off
   task automatic send(input logic off, input int wid);
      @(posedge clk_i);
      #1;
      pos_o = !off;
      neg_o = off;
      repeat (wid) @(posedge clk_i);
      #1;
      pos_o = 1'h0;
      neg_o = 1'h0;
      repeat (12) @(posedge clk_i);
      #1;
   endtask
   // stop command
   task automatic stop();
      repeat (3) send(1'h1, 5);
   endtask
endmodule // fbsfc_sec_model
`default_nettype wire

// ---- flyback_startup_fault_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the sequencer
// Assumes: shortened counts at the instance
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
module flyback_startup_fault_ctrl_tb_top;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic uv = 1'h0;
   logic line_ov = 1'h0;
   logic aux_ov = 1'h0;
   logic oc = 1'h0;
   logic pos, neg, gate, xcap, dis, ss, cl, sd;
   int mismatches = 0;
   int total_checks = 0;
   int cyc = 0;
   always #20 clk = ~clk;
   fbsfc_ctrl #(.OSC_DIV(10'h341), .RESTART_OSC(20'h3), .SS_STEP(10'h32), .XCAP_WIN(32'hc8),
      .STOP_DLY(32'h64)) u_dut (.CLK_I(clk), .RST_B_I(rst_b),
      .LINE_UV_OK_I(uv), .LINE_OV_I(line_ov), .AUX_OV_I(aux_ov), .OVERCURRENT_I(oc),
      .SYNC_POS_I(pos), .SYNC_NEG_I(neg), .GATE_DRIVE_O(gate), .XCAP_MODE_O(xcap),
      .DISCHARGE_EN_O(dis), .SOFTSTART_O(ss), .CLOSED_LOOP_O(cl), .SHUTDOWN_O(sd));
   fbsfc_sec_model u_sec (.clk_i(clk), .pos_o(pos), .neg_o(neg));
   task automatic results();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         mismatches = mismatches + 1;
         results();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_on(ref logic s, input logic v, input int lim);
      for (int i = 0; i < lim && s !== v; i++) tick(1);
      check(16'(s), 16'(v));
   endtask
   task automatic t_xcap();
      for (int i = 0; i < 3; i++) begin
         uv = 1'h1;
         tick(10);
         uv = 1'h0;
         tick(10);
      end
      wait_on(xcap, 1'h1, 30);
      check(16'(dis), 16'h0);
      wait_on(dis, 1'h1, 450);
   endtask
   task automatic t_ramp();
      int w;
      tick(5);
      uv = 1'h1;
      wait_on(ss, 1'h1, 10);
      for (int i = 1; i <= 10; i++) begin
         wait_on(gate, 1'h1, 900);
         w = 0;
         while (gate === 1'h1 && w < 700) begin
            tick(1);
            w++;
         end
         check(16'(w), (i < 10) ? 16'(50 * i) : 16'h1db);
      end
   endtask
   task automatic t_fault(input int sel);
      {line_ov, aux_ov, oc} = 3'h4 >> sel;
      tick(5);
      check(16'(gate), 16'h0);
      check(16'(ss), 16'h0);
      {line_ov, aux_ov, oc} = 3'h0;
      tick(100);
      check(16'(ss), 16'h0);
      wait_on(ss, 1'h1, 3500);
   endtask
   task automatic t_sync();
      u_sec.send(1'h0, 60);
      check(16'(cl), 16'h0);
      u_sec.send(1'h0, 5);
      check(16'(cl), 16'h1);
      check(16'(gate), 16'h1);
      aux_ov = 1'h1;
      oc = 1'h1;
      tick(5);
      check(16'(gate), 16'h0);
      check(16'(cl), 16'h1);
      oc = 1'h0;
      u_sec.send(1'h0, 5);
      check(16'(gate), 16'h1);
      u_sec.send(1'h1, 5);
      check(16'(gate), 16'h0);
      aux_ov = 1'h0;
   endtask
   task automatic t_timeout();
      u_sec.send(1'h0, 5);
      tick(600);
      check(16'(gate), 16'h1);
      tick(30);
      check(16'(gate), 16'h0);
      wait_on(ss, 1'h1, 3500);
   endtask
   task automatic t_stop();
      u_sec.send(1'h0, 5);
      u_sec.stop();
      check(16'(gate), 16'h0);
      tick(40);
      check(16'(sd), 16'h0);
      wait_on(sd, 1'h1, 80);
      uv = 1'h0;
      tick(5);
      uv = 1'h1;
      tick(20);
      check(16'(sd), 16'h1);
      check(16'(ss), 16'h0);
   endtask
   initial begin
      tick(3);
      check(16'({gate, xcap, dis, ss, cl, sd}), 16'h0);
      rst_b = 1'h1;
      t_xcap();
      t_ramp();
      for (int s = 0; s < 3; s++) t_fault(s);
      t_sync();
      t_timeout();
      t_stop();
      results();
   end
endmodule // flyback_startup_fault_ctrl_tb_top
`default_nettype wire
